// File: logic/sercr_params.svh
// constants of the serializer control register bank: offsets, field positions, reset values, masks
// assumes inclusion by sercr_pkg.sv and sercr_regs.sv only
`ifndef SERCR_PARAMS_SVH
`define SERCR_PARAMS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define SERCR_OFF_DEVADDR   8'h00
`define SERCR_OFF_RESET     8'h01
`define SERCR_OFF_CONFIG    8'h03

// ----------------------------------------
// reset values and writable masks
// ----------------------------------------
`define SERCR_RST_DEVADDR   8'h00
`define SERCR_RST_RESET     8'h00
`define SERCR_RST_CONFIG    8'hd2
`define SERCR_WMASK_DEVADDR 8'hff
`define SERCR_WMASK_RESET   8'h80
`define SERCR_WMASK_CONFIG  8'hbb

// ----------------------------------------
// field positions
// ----------------------------------------
`define SERCR_BIT_ADDR_OVR  0
`define SERCR_BIT_AUTO_PD   7
`define SERCR_BIT_FULL_RST  1
`define SERCR_BIT_LOGIC_RST 0
`define SERCR_BIT_CRC_EN    7
`define SERCR_BIT_AUTO_ACK  5
`define SERCR_BIT_FILTER    4
`define SERCR_BIT_PASSTHRU  3
`define SERCR_BIT_OSC_AUTO  1
`define SERCR_BIT_EDGE      0

// ----------------------------------------
// strap address and timing
// ----------------------------------------
`define SERCR_STRAP_BASE    7'h0c
`define SERCR_STRAP_WAIT    2'h3
`define SERCR_RST_PULSE     4

`endif

// File: logic/sercr_pkg.sv
// types of the serializer control register bank
// assumes sercr_params.svh is on the include path
`include "sercr_params.svh"

package sercr_pkg;

  // register port request from the serial bus engine
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sercr_req_s;

  // configuration fields driven to the datapath
  typedef struct packed {
    logic crc_check_en;
    logic remote_wr_auto_ack;
    logic sync_filter_en;
    logic passthru_en;
    logic osc_auto_switch_en;
    logic sample_edge_rising;
  } sercr_cfg_s;

  typedef enum logic [1:0] {
    SERCR_REG_DEVADDR,
    SERCR_REG_RESET,
    SERCR_REG_CONFIG,
    SERCR_REG_NONE
  } sercr_reg_e;

  typedef enum logic [1:0] {
    SERCR_RUN,
    SERCR_FULL_RST,
    SERCR_LOGIC_RST
  } sercr_state_e;

endpackage : sercr_pkg

// File: logic/sercr_regs.sv
// control register bank of the video serializer: address override, power and soft resets, link config
// assumes a serial bus engine on CLK_SYS presenting one-cycle read/write strobes, and a strap level pin
`timescale 1ns/1ps
`default_nettype none
`include "sercr_params.svh"

module sercr_regs
  import sercr_pkg::*;
#(
  parameter int RST_PULSE_CYCLES = `SERCR_RST_PULSE
) (
  // clock and reset
  input  wire  logic       CLK_SYS,
  input  wire  logic       RST,
  // register port from the serial bus engine
  input  wire  sercr_req_s REG_REQ,
  output var   logic [7:0] REG_RDATA,
  output var   logic       REG_RVALID,
  // strap pin level, already quantised to 16 steps
  input  wire  logic [3:0] ADDRESS_STRAP_PIN,
  // status from the link and clock monitors, same clock
  input  wire  logic       LINK_DETECTED,
  input  wire  logic       PIXEL_CLOCK_ABSENT,
  // controls to the device
  output var   logic [6:0] TARGET_ADDRESS,
  output var   logic       POWER_DOWN,
  output var   logic       DIGITAL_RESET,
  output var   logic       USE_INTERNAL_OSCILLATOR,
  output var   sercr_cfg_s CFG
);

  localparam logic [3:0] PULSE_LEN = 4'(RST_PULSE_CYCLES);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic sercr_reg_e decode(input logic [7:0] addr);
    case (addr)
      `SERCR_OFF_DEVADDR: decode = SERCR_REG_DEVADDR;
      `SERCR_OFF_RESET:   decode = SERCR_REG_RESET;
      `SERCR_OFF_CONFIG:  decode = SERCR_REG_CONFIG;
      default:            decode = SERCR_REG_NONE;
    endcase
  endfunction : decode

  // strap steps map to consecutive addresses from the base
  function automatic logic [6:0] strap_address(input logic [3:0] step);
    strap_address = `SERCR_STRAP_BASE + {3'h0, step};
  endfunction : strap_address

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [3:0]   strap_meta_r, strap_sync_r;
  logic [3:0]   strap_r, strap_nxt;
  logic [1:0]   strap_wait_r, strap_wait_nxt;
  logic [7:0]   devaddr_r, devaddr_nxt;
  logic [7:0]   rstreg_r, rstreg_nxt;
  logic [7:0]   config_r, config_nxt;
  sercr_state_e state_r, state_nxt;
  logic [3:0]   pulse_cnt_r, pulse_cnt_nxt;
  logic [7:0]   rdata_r, rdata_nxt;
  logic         rvalid_r, rvalid_nxt;
  logic [6:0]   target_r, target_nxt;
  logic         pd_r, pd_nxt;
  logic         dig_rst_r, dig_rst_nxt;
  logic         osc_r, osc_nxt;
  sercr_cfg_s   cfg_r, cfg_nxt;
  sercr_reg_e   sel;
  logic [7:0]   rst_view;

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always_comb begin
    sel            = decode(REG_REQ.addr);
    strap_nxt      = strap_r;
    strap_wait_nxt = strap_wait_r;
    devaddr_nxt    = devaddr_r;
    rstreg_nxt     = rstreg_r;
    config_nxt     = config_r;
    state_nxt      = state_r;
    pulse_cnt_nxt  = pulse_cnt_r;
    rdata_nxt      = rdata_r;
    rvalid_nxt     = 1'b0;

    // strap loaded on the first three cycles after reset release, the last once the synchroniser has settled, then held
    if (strap_wait_r != `SERCR_STRAP_WAIT) begin
      strap_wait_nxt = strap_wait_r + 2'h1;
      strap_nxt      = strap_sync_r;
    end

    // reset bits read one while their pulse runs, zero once it ends
    rst_view = rstreg_r & `SERCR_WMASK_RESET;
    rst_view[`SERCR_BIT_FULL_RST]  = (state_r == SERCR_FULL_RST);
    rst_view[`SERCR_BIT_LOGIC_RST] = (state_r == SERCR_LOGIC_RST);

    case (state_r)
      SERCR_RUN: begin
        if (REG_REQ.wr) begin
          case (sel)
            SERCR_REG_DEVADDR: devaddr_nxt = REG_REQ.wdata & `SERCR_WMASK_DEVADDR;
            SERCR_REG_RESET: begin
              rstreg_nxt = REG_REQ.wdata & `SERCR_WMASK_RESET;
              // full reset outranks the logic-only reset when both are written
              if (REG_REQ.wdata[`SERCR_BIT_FULL_RST]) begin
                state_nxt     = SERCR_FULL_RST;
                pulse_cnt_nxt = PULSE_LEN;
              end else if (REG_REQ.wdata[`SERCR_BIT_LOGIC_RST]) begin
                state_nxt     = SERCR_LOGIC_RST;
                pulse_cnt_nxt = PULSE_LEN;
              end
            end
            SERCR_REG_CONFIG:  config_nxt = REG_REQ.wdata & `SERCR_WMASK_CONFIG;
            default: ;
          endcase
        end
      end
      SERCR_FULL_RST, SERCR_LOGIC_RST: begin
        // writes during a soft reset are dropped; the bank is being cleared or held
        pulse_cnt_nxt = pulse_cnt_r - 4'h1;
        if (state_r == SERCR_FULL_RST) begin
          devaddr_nxt = `SERCR_RST_DEVADDR;
          rstreg_nxt  = `SERCR_RST_RESET;
          config_nxt  = `SERCR_RST_CONFIG & `SERCR_WMASK_CONFIG;
        end
        if (pulse_cnt_r == 4'h1) begin
          state_nxt = SERCR_RUN;
        end
      end
      default: state_nxt = SERCR_RUN;
    endcase

    if (REG_REQ.rd) begin
      rvalid_nxt = 1'b1;
      case (sel)
        SERCR_REG_DEVADDR: rdata_nxt = devaddr_r;
        SERCR_REG_RESET:   rdata_nxt = rst_view;
        SERCR_REG_CONFIG:  rdata_nxt = config_r & `SERCR_WMASK_CONFIG;
        default:           rdata_nxt = 8'h00;
      endcase
    end

    // outputs follow the registers one cycle later, except DIGITAL_RESET, which is taken from state_nxt and moves with state_r
    if (devaddr_r[`SERCR_BIT_ADDR_OVR]) begin
      target_nxt = devaddr_r[7:1];
    end else begin
      target_nxt = strap_address(strap_r);
    end
    pd_nxt      = rstreg_r[`SERCR_BIT_AUTO_PD] & ~LINK_DETECTED;
    dig_rst_nxt = (state_nxt != SERCR_RUN);
    osc_nxt     = config_r[`SERCR_BIT_OSC_AUTO] & PIXEL_CLOCK_ABSENT;
    cfg_nxt.crc_check_en       = config_r[`SERCR_BIT_CRC_EN];
    cfg_nxt.remote_wr_auto_ack = config_r[`SERCR_BIT_AUTO_ACK];
    cfg_nxt.sync_filter_en     = config_r[`SERCR_BIT_FILTER];
    cfg_nxt.passthru_en        = config_r[`SERCR_BIT_PASSTHRU];
    cfg_nxt.osc_auto_switch_en = config_r[`SERCR_BIT_OSC_AUTO];
    cfg_nxt.sample_edge_rising = config_r[`SERCR_BIT_EDGE];
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      strap_meta_r <= 4'h0;
      strap_sync_r <= 4'h0;
      strap_r      <= 4'h0;
      strap_wait_r <= 2'h0;
      devaddr_r    <= `SERCR_RST_DEVADDR;
      rstreg_r     <= `SERCR_RST_RESET;
      config_r     <= `SERCR_RST_CONFIG & `SERCR_WMASK_CONFIG;
      state_r      <= SERCR_RUN;
      pulse_cnt_r  <= 4'h0;
      rdata_r      <= 8'h00;
      rvalid_r     <= 1'b0;
      target_r     <= `SERCR_STRAP_BASE;
      pd_r         <= 1'b0;
      dig_rst_r    <= 1'b0;
      osc_r        <= 1'b0;
      cfg_r        <= '0;
    end else begin
      strap_meta_r <= ADDRESS_STRAP_PIN;
      strap_sync_r <= strap_meta_r;
      strap_r      <= strap_nxt;
      strap_wait_r <= strap_wait_nxt;
      devaddr_r    <= devaddr_nxt;
      rstreg_r     <= rstreg_nxt;
      config_r     <= config_nxt;
      state_r      <= state_nxt;
      pulse_cnt_r  <= pulse_cnt_nxt;
      rdata_r      <= rdata_nxt;
      rvalid_r     <= rvalid_nxt;
      target_r     <= target_nxt;
      pd_r         <= pd_nxt;
      dig_rst_r    <= dig_rst_nxt;
      osc_r        <= osc_nxt;
      cfg_r        <= cfg_nxt;
    end
  end

  assign REG_RDATA               = rdata_r;
  assign REG_RVALID              = rvalid_r;
  assign TARGET_ADDRESS          = target_r;
  assign POWER_DOWN              = pd_r;
  assign DIGITAL_RESET           = dig_rst_r;
  assign USE_INTERNAL_OSCILLATOR = osc_r;
  assign CFG                     = cfg_r;

endmodule : sercr_regs

`default_nettype wire

// File: test/sercr_host.sv
// bench-side host standing in for the serial bus engine
// assumes one-cycle strobes taken at the next CLK_SYS rise
`timescale 1ns/1ps
`default_nettype none
module sercr_host
  import sercr_pkg::*;
(
  // clock
  input  wire logic       clk,
  // register port
  output var  sercr_req_s req,
  input  wire logic [7:0] rdata,
  input  wire logic       rvalid
);
  initial req = '0;
  // released fields show inverted values so stale data is never mistaken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    req <= '{1'b0, 1'b0, ~a, ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge clk);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    req <= '{1'b0, 1'b0, ~a, 8'hff};
    #1;
    ok = rvalid;
    d  = rdata;
  endtask : rd
endmodule : sercr_host
`default_nettype wire

// File: test/sercr_regs_props.sv
// port checker of the control register bank
// assumes bind onto sercr_regs, register port on CLK_SYS
`timescale 1ns/1ps
`default_nettype none
module sercr_chk
  import sercr_pkg::*;
#(
  parameter int RST_PULSE_CYCLES = 4
) (
  // clock and reset
  input wire logic       CLK_SYS,
  input wire logic       RST,
  // register port and status
  input wire sercr_req_s REG_REQ,
  input wire logic [7:0] REG_RDATA,
  input wire logic       REG_RVALID,
  input wire logic       LINK_DETECTED,
  input wire logic       PIXEL_CLOCK_ABSENT,
  // controls
  input wire logic [6:0] TARGET_ADDRESS,
  input wire logic       POWER_DOWN,
  input wire logic       DIGITAL_RESET,
  input wire logic       USE_INTERNAL_OSCILLATOR,
  input wire sercr_cfg_s CFG
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  wire logic [7:0] a = REG_REQ.addr;
  wire logic [7:0] d = REG_REQ.wdata;
  // writes during a soft reset are dropped, so only clean ones count
  wire logic       w = REG_REQ.wr && !DIGITAL_RESET;
  // config fields as written; compared two cycles on, when the host has long moved on
  wire logic [5:0] d_cfg = {d[7], d[5:3], d[1:0]};
  cfg_follow_a: assert property (w && a == 8'h03 |-> ##2
    CFG == $past(d_cfg, 2)) else $error("config outputs off");
  addr_ovr_a: assert property (w && a == 8'h00 && d[0] |-> ##2 TARGET_ADDRESS == $past(d[7:1], 2))
    else $error("override address off");
  pwr_down_a: assert property (POWER_DOWN |-> !$past(LINK_DETECTED)) else $error("power down with link");
  osc_sw_a: assert property (!DIGITAL_RESET && !$past(DIGITAL_RESET) |->
    USE_INTERNAL_OSCILLATOR == (CFG.osc_auto_switch_en && $past(PIXEL_CLOCK_ABSENT))) else $error("osc switch off");
  rst_start_a: assert property (w && a == 8'h01 && |d[1:0] |=> DIGITAL_RESET) else $error("no soft reset");
  rst_pulse_a: assert property ($rose(DIGITAL_RESET) |-> DIGITAL_RESET[*4] ##1 !DIGITAL_RESET)
    else $error("soft reset length off");
  rsvd_zero_a: assert property (REG_REQ.rd && a == 8'h03 |=> !REG_RDATA[6] && !REG_RDATA[2])
    else $error("reserved bit read one");
  unmapped_a: assert property (REG_REQ.rd && (a == 8'h02 || a > 8'h03) |=> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  // run length of a soft reset pulse, counted so the check follows the parameter
  int rst_len_r;
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      rst_len_r <= 0;
    end else if (DIGITAL_RESET) begin
      rst_len_r <= rst_len_r + 1;
    end else begin
      rst_len_r <= 0;
    end
  end
  rst_len_a: assert property ($fell(DIGITAL_RESET) |-> rst_len_r == RST_PULSE_CYCLES)
    else $error("soft reset length not as configured");
  rd_answer_a: assert property (REG_RVALID == $past(REG_REQ.rd))
    else $error("read answer not one cycle after strobe");
  cover property (REG_REQ.rd && a == 8'h03);
  cover property ($rose(DIGITAL_RESET));
  cover property (POWER_DOWN);
endmodule : sercr_chk
bind sercr_regs sercr_chk #(.RST_PULSE_CYCLES(RST_PULSE_CYCLES)) i_chk (.CLK_SYS(CLK_SYS), .RST(RST),
  .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .LINK_DETECTED(LINK_DETECTED),
  .PIXEL_CLOCK_ABSENT(PIXEL_CLOCK_ABSENT),
  .TARGET_ADDRESS(TARGET_ADDRESS), .POWER_DOWN(POWER_DOWN), .DIGITAL_RESET(DIGITAL_RESET),
  .USE_INTERNAL_OSCILLATOR(USE_INTERNAL_OSCILLATOR), .CFG(CFG));
`default_nettype wire

// File: test/tb_top.sv
// self-checking bench of the control register bank
// assumes sercr_host as register master and the bound port checker
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sercr_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [3:0] strap = 4'h5;
  logic       link = 1'b1;
  logic       absent = 1'b0;
  sercr_req_s req;
  sercr_cfg_s cfg;
  logic [7:0] rdata;
  logic [7:0] rv;
  logic [7:0] w;
  logic [6:0] ta;
  logic       rvalid, pd, dr, uio, ok;
  int         error_cnt = 0;
  int         n_checks = 0;
  always #2.5 clk = ~clk;
  sercr_host i_host (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));
  sercr_regs #(.RST_PULSE_CYCLES(4)) i_dut (.CLK_SYS(clk), .RST(rst), .REG_REQ(req), .REG_RDATA(rdata),
    .REG_RVALID(rvalid), .ADDRESS_STRAP_PIN(strap), .LINK_DETECTED(link), .PIXEL_CLOCK_ABSENT(absent),
    .TARGET_ADDRESS(ta), .POWER_DOWN(pd), .DIGITAL_RESET(dr), .USE_INTERNAL_OSCILLATOR(uio), .CFG(cfg));
  task automatic print_verdict;
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    i_host.rd(a, rv, ok);
    chk({7'h00, ok}, 8'h01);
    chk(rv, e);
  endtask : rchk
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle
  task automatic wait_rst;
    int i;
    for (i = 0; i < 50 && dr !== 1'b0; i++) idle(1);
    if (i == 50) begin
      error_cnt++;
      print_verdict();
    end
  endtask : wait_rst
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    idle(6);
    chk({1'b0, ta}, 8'h11);
    chk({2'b00, cfg}, 8'h2a);
    rchk(8'h03, 8'h92);
    rchk(8'h01, 8'h00);
    rchk(8'h02, 8'h00);
    rchk(8'h07, 8'h00);
    for (int b = 0; b < 8; b++) begin
      w = 8'h01 << b;
      i_host.wr(8'h03, w);
      rchk(8'h03, w & 8'hbb);
      chk({2'b00, cfg}, {2'b00, w[7], w[5:3], w[1:0]});
    end
    @(posedge clk) absent <= 1'b1;
    idle(3);
    chk({7'h00, uio}, 8'h00);
    i_host.wr(8'h03, 8'h02);
    idle(3);
    chk({7'h00, uio}, 8'h01);
    @(posedge clk) absent <= 1'b0;
    idle(3);
    chk({7'h00, uio}, 8'h00);
    i_host.wr(8'h00, 8'h55);
    idle(3);
    chk({1'b0, ta}, 8'h2a);
    rchk(8'h00, 8'h55);
    i_host.wr(8'h00, 8'h54);
    idle(3);
    chk({1'b0, ta}, 8'h11);
    i_host.wr(8'h01, 8'hfc);
    rchk(8'h01, 8'h80);
    chk({7'h00, pd}, 8'h00);
    @(posedge clk) link <= 1'b0;
    idle(3);
    chk({7'h00, pd}, 8'h01);
    i_host.wr(8'h01, 8'h00);
    idle(3);
    chk({7'h00, pd}, 8'h00);
    i_host.wr(8'h01, 8'h80);
    i_host.wr(8'h03, 8'h00);
    i_host.wr(8'h01, 8'h83);
    // the write edge launches the reset flag; look once it has settled
    idle(0);
    chk({7'h00, dr}, 8'h01);
    i_host.wr(8'h00, 8'hff);
    wait_rst();
    rchk(8'h03, 8'h92);
    rchk(8'h01, 8'h00);
    rchk(8'h00, 8'h00);
    i_host.wr(8'h03, 8'h08);
    i_host.wr(8'h01, 8'h01);
    idle(1);
    chk({7'h00, dr}, 8'h01);
    wait_rst();
    rchk(8'h03, 8'h08);
    rchk(8'h01, 8'h00);
    // second reset with another strap level; the strap is only caught after a reset
    @(posedge clk) begin
      rst   <= 1'b1;
      strap <= 4'hf;
    end
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    idle(6);
    chk({1'b0, ta}, 8'h1b);
    chk({2'b00, cfg}, 8'h2a);
    rchk(8'h00, 8'h00);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
